/* File: hw/cie_exec_core.sv */
// execute stage for the and, bit, skip, clear and call subset
`default_nettype none
module cie_exec_core (
    // clock and reset
    input  wire logic                       mclk,
    input  wire logic                       resetn,
    // instruction in
    input  wire logic                       instr_valid,
    input  wire logic [cie_pkg::INSTR_W-1:0] instr,
    // pins and timer option
    input  wire logic [cie_pkg::DATA_W-1:0] io_pins,
    input  wire logic                       prescaler_on_timer,
    // core state
    output logic      [cie_pkg::DATA_W-1:0] accumulator,
    output logic      [cie_pkg::DATA_W-1:0] status,
    output logic      [cie_pkg::PC_W-1:0]   program_counter,
    output logic      [cie_pkg::DATA_W-1:0] io_latch,
    // events
    output logic                            stack_push,
    output logic      [cie_pkg::PC_W-1:0]   stack_push_addr,
    output logic                            prescaler_clear,
    output logic                            idle_op
);
    import cie_pkg::*;

    typedef struct packed {
        logic [DATA_W-1:0] acc;
        logic [DATA_W-1:0] stat;
        logic [PC_W-1:0]   pc;
        logic [DATA_W-1:0] latch;
        logic              flush;
        logic              push;
        logic [PC_W-1:0]   push_addr;
        logic              psc_clr;
        logic              idle;
    } cie_core_s;

    cie_core_s st_q;
    cie_core_s st_d;

    cie_file_if #(.AW(FADDR_W), .DW(DATA_W)) fif ();

    // general file locations; status and io port are overlaid in the core
    cie_file_mem #(
        .DEPTH (FILE_MAX + 1)
    ) u_mem (
        .mclk   (mclk),
        .resetn (resetn),
        .fif    (fif)
    );

    function automatic cie_op_e decode(input logic [INSTR_W-1:0] w);
        cie_op_e op;
        op = CIE_OP_IDLE;
        if (w == OPC_CLEAR_ACC) begin
            op = CIE_OP_CLR_ACC;
        end else if (w[11:6] == OPC_AND_FILE) begin
            op = CIE_OP_AND_FILE;
        end else begin
            unique case (w[11:8])
                OPC_AND_LITERAL: op = CIE_OP_AND_LIT;
                OPC_CALL:        op = CIE_OP_CALL;
                OPC_BIT_SET:     op = CIE_OP_BIT_SET;
                OPC_SKIP_CLEAR:  op = CIE_OP_SKIP_CLR;
                OPC_SKIP_SET:    op = CIE_OP_SKIP_SET;
                default:         op = CIE_OP_IDLE;
            endcase
        end
        return op;
    endfunction

    // one-hot mask of the bit field
    function automatic logic [DATA_W-1:0] bit_mask(input logic [2:0] b);
        return DATA_W'(1) << b;
    endfunction

    // zero flag update for logic results
    function automatic logic [DATA_W-1:0] with_zero(input logic [DATA_W-1:0] s,
                                                    input logic [DATA_W-1:0] r);
        logic [DATA_W-1:0] o;
        o = s;
        o[ST_ZERO] = (r == '0);
        return o;
    endfunction

    // address of the word after the current one
    function automatic logic [PC_W-1:0] step_pc(input logic [PC_W-1:0] p);
        return p + PC_W'(1);
    endfunction

    // state of one selected bit of a file value
    function automatic logic bit_of(input logic [DATA_W-1:0] v, input logic [2:0] b);
        return (v & bit_mask(b)) != '0;
    endfunction

    cie_op_e           op;
    logic [FADDR_W-1:0] faddr;
    logic [2:0]        bsel;
    logic [DATA_W-1:0] lit;
    logic [DATA_W-1:0] fval;
    logic [DATA_W-1:0] res;

    assign op    = decode(instr);
    assign faddr = instr[F_ADDR_LSB +: FADDR_W];
    assign bsel  = instr[F_BIT_LSB +: 3];
    assign lit   = instr[F_LIT_LSB +: DATA_W];
    assign fif.raddr = faddr;

    // file read: status from core, io port from pins
    always_comb begin
        if (faddr == ADDR_STATUS) begin
            fval = st_q.stat;
        end else if (faddr == ADDR_IO_PORT) begin
            fval = io_pins;
        end else begin
            fval = fif.rdata;
        end
    end

    always_comb begin
        st_d         = st_q;
        st_d.push    = 1'b0;
        st_d.psc_clr = 1'b0;
        st_d.idle    = 1'b0;
        fif.we       = 1'b0;
        fif.waddr    = faddr;
        fif.wdata    = '0;
        res          = '0;
        if (instr_valid) begin
            st_d.pc = step_pc(st_q.pc);
            if (st_q.flush) begin
                // prefetched word dropped, idle in its place
                st_d.flush = 1'b0;
                st_d.idle  = 1'b1;
            end else begin
                unique case (op)
                    CIE_OP_AND_LIT: begin
                        res       = st_q.acc & lit;
                        st_d.acc  = res;
                        st_d.stat = with_zero(st_q.stat, res);
                    end
                    CIE_OP_AND_FILE: begin
                        res       = st_q.acc & fval;
                        st_d.stat = with_zero(st_q.stat, res);
                        if (instr[F_DEST_BIT]) begin
                            fif.we    = 1'b1;
                            fif.wdata = res;
                        end else begin
                            st_d.acc = res;
                        end
                    end
                    CIE_OP_BIT_SET: begin
                        res       = fval | bit_mask(bsel);
                        fif.we    = 1'b1;
                        fif.wdata = res;
                    end
                    CIE_OP_SKIP_CLR: begin
                        st_d.flush = !bit_of(fval, bsel);
                    end
                    CIE_OP_SKIP_SET: begin
                        st_d.flush = bit_of(fval, bsel);
                    end
                    CIE_OP_CLR_ACC: begin
                        st_d.acc            = '0;
                        st_d.stat[ST_ZERO]  = 1'b1;
                    end
                    CIE_OP_CALL: begin
                        // return address latched in the same cycle as the counter is reloaded
                        st_d.push      = 1'b1;
                        st_d.push_addr = step_pc(st_q.pc);
                        st_d.pc        = {st_q.stat[ST_PAGE_MSB:ST_PAGE_LSB], 1'b0, lit};
                        st_d.flush     = 1'b1;
                    end
                    CIE_OP_IDLE: begin
                        st_d.idle = 1'b1;
                    end
                endcase
                // side effects of a file write on the special locations
                if (fif.we) begin
                    if (faddr == ADDR_STATUS) begin
                        // explicit status write wins over the zero flag
                        st_d.stat = fif.wdata;
                    end
                    if (faddr == ADDR_IO_PORT) begin
                        st_d.latch = fif.wdata;
                    end
                    if (faddr == ADDR_TIMER_ZERO && prescaler_on_timer) begin
                        st_d.psc_clr = 1'b1;
                    end
                end
            end
        end
    end

    // whole core state registered at once
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '{
                acc:       RST_ACC,
                stat:      RST_STATUS,
                pc:        RST_PC,
                latch:     RST_LATCH,
                flush:     1'b0,
                push:      1'b0,
                push_addr: RST_PC,
                psc_clr:   1'b0,
                idle:      1'b0
            };
        end else begin
            st_q <= st_d;
        end
    end

    assign accumulator     = st_q.acc;
    assign status          = st_q.stat;
    assign program_counter = st_q.pc;
    assign io_latch        = st_q.latch;
    assign stack_push      = st_q.push;
    assign stack_push_addr = st_q.push_addr;
    assign prescaler_clear = st_q.psc_clr;
    assign idle_op         = st_q.idle;
endmodule // cie_exec_core
`default_nettype wire

/* File: shared/cie_pkg.sv */
// constants and types for the instruction execute subset
`default_nettype none
package cie_pkg;
    localparam int INSTR_W   = 12;
    localparam int DATA_W    = 8;
    localparam int FADDR_W   = 5;
    localparam int PC_W      = 11;
    localparam int FILE_MAX  = 31;
    // opcode patterns
    localparam logic [3:0]  OPC_AND_LITERAL  = 4'hE;
    localparam logic [3:0]  OPC_CALL         = 4'h9;
    localparam logic [3:0]  OPC_BIT_SET      = 4'h5;
    localparam logic [3:0]  OPC_SKIP_CLEAR   = 4'h6;
    localparam logic [3:0]  OPC_SKIP_SET     = 4'h7;
    localparam logic [5:0]  OPC_AND_FILE     = 6'h05;
    localparam logic [11:0] OPC_CLEAR_ACC    = 12'h040;
    // field positions
    localparam int F_ADDR_LSB = 0;
    localparam int F_DEST_BIT = 5;
    localparam int F_BIT_LSB  = 5;
    localparam int F_LIT_LSB  = 0;
    // special file addresses
    localparam logic [4:0]  ADDR_TIMER_ZERO = 5'h01;
    localparam logic [4:0]  ADDR_STATUS     = 5'h03;
    localparam logic [4:0]  ADDR_IO_PORT    = 5'h06;
    // status fields and the counter bit 8 position
    localparam int ST_ZERO     = 2;
    localparam int ST_PAGE_LSB = 5;
    localparam int ST_PAGE_MSB = 6;
    localparam int PC_BIT8     = 8;
    // reset values
    localparam logic [7:0]  RST_ACC    = 8'h00;
    localparam logic [7:0]  RST_STATUS = 8'h18;
    localparam logic [10:0] RST_PC     = 11'h000;
    localparam logic [7:0]  RST_LATCH  = 8'h00;

    typedef enum logic [2:0] {
        CIE_OP_IDLE, CIE_OP_AND_LIT, CIE_OP_AND_FILE, CIE_OP_BIT_SET,
        CIE_OP_SKIP_CLR, CIE_OP_SKIP_SET, CIE_OP_CLR_ACC, CIE_OP_CALL
    } cie_op_e;
endpackage
`default_nettype wire

/* File: shared/cie_file_if.sv */
// register file access between core and storage
`default_nettype none
interface cie_file_if #(parameter int AW = 5, parameter int DW = 8);
    logic [AW-1:0] raddr;
    logic [DW-1:0] rdata;
    logic          we;
    logic [AW-1:0] waddr;
    logic [DW-1:0] wdata;
    modport core (output raddr, output we, output waddr, output wdata, input rdata);
    modport mem  (input raddr, input we, input waddr, input wdata, output rdata);
endinterface
`default_nettype wire

/* File: hw/cie_file_mem.sv */
// general purpose register file storage
`default_nettype none
module cie_file_mem #(
    parameter int DEPTH = 32
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic resetn,
    // access port
    cie_file_if.mem   fif
);
    import cie_pkg::*;

    logic [DATA_W-1:0] mem_q [DEPTH];

    assign fif.rdata = mem_q[fif.raddr];

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else if (fif.we) begin
            mem_q[fif.waddr] <= fif.wdata;
        end
    end
endmodule // cie_file_mem
`default_nettype wire

/* File: tb/cie_exec_checker.sv */
// assertions on the execute core ports
`default_nettype none
module cie_exec_checker (
    // clock and reset
    input wire logic                         mclk,
    input wire logic                         resetn,
    // instruction in
    input wire logic                         instr_valid,
    input wire logic [cie_pkg::INSTR_W-1:0]  instr,
    input wire logic                         prescaler_on_timer,
    // core state and events
    input wire logic [cie_pkg::DATA_W-1:0]   accumulator,
    input wire logic [cie_pkg::DATA_W-1:0]   status,
    input wire logic [cie_pkg::PC_W-1:0]     program_counter,
    input wire logic                         stack_push,
    input wire logic [cie_pkg::PC_W-1:0]     stack_push_addr,
    input wire logic                         prescaler_clear,
    input wire logic                         idle_op
);
    import cie_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    sequence s_take(logic [3:0] op);
        instr_valid && instr[11:8] == op;
    endsequence
    sequence s_call_run;
        s_take(OPC_CALL) ##1 !idle_op;
    endsequence
    a_clracc_zero:
    assert property (instr_valid && instr == OPC_CLEAR_ACC |=> idle_op
        || (accumulator == 8'h00 && status[ST_ZERO])) else $error("clear acc wrong");
    a_andlit_result:
    assert property (s_take(OPC_AND_LITERAL) |=> idle_op
        || (accumulator == ($past(accumulator) & $past(instr[7:0]))
        && status[ST_ZERO] == (accumulator == 8'h00))) else $error("and literal wrong");
    a_andfile_flags:
    assert property (instr_valid && instr[11:6] == OPC_AND_FILE && instr[4:0] != ADDR_STATUS
        |=> idle_op || (status & 8'hFB) == ($past(status) & 8'hFB)) else $error("and flags");
    a_call_target:
    assert property (s_take(OPC_CALL) |=> idle_op || (stack_push
        && stack_push_addr == $past(program_counter) + 11'h001 && status == $past(status)
        && program_counter == {$past(status[ST_PAGE_MSB:ST_PAGE_LSB]), 1'b0,
        $past(instr[7:0])})) else $error("call target wrong");
    a_call_discard:
    assert property (s_call_run ##0 instr_valid |=> idle_op) else $error("call no discard");
    a_skip_flags:
    assert property (instr_valid && (instr[11:8] == OPC_SKIP_CLEAR
        || instr[11:8] == OPC_SKIP_SET) |=> $stable(status)) else $error("skip flags");
    a_bitset_flags:
    assert property (instr_valid && instr[11:8] == OPC_BIT_SET && instr[4:0] != ADDR_STATUS
        |=> $stable(status)) else $error("bit set flags");
    a_pc_step:
    assert property (instr_valid && instr[11:8] != OPC_CALL
        |=> program_counter == $past(program_counter) + 11'h001) else $error("pc step");
    a_push_pulse:
    assert property (stack_push |=> !stack_push) else $error("push too long");
    a_timer_psc_clear:
    assert property (instr_valid && instr[11:8] == OPC_BIT_SET && instr[4:0] == ADDR_TIMER_ZERO
        |=> idle_op || prescaler_clear == $past(prescaler_on_timer))
        else $error("prescaler clear wrong");
endmodule // cie_exec_checker
bind cie_exec_core cie_exec_checker u_chk (.mclk(mclk), .resetn(resetn),
    .instr_valid(instr_valid), .instr(instr), .prescaler_on_timer(prescaler_on_timer),
    .accumulator(accumulator), .status(status), .program_counter(program_counter),
    .stack_push(stack_push), .stack_push_addr(stack_push_addr),
    .prescaler_clear(prescaler_clear), .idle_op(idle_op));
`default_nettype wire

/* File: tb/core_instruction_execute_subset_tb.sv */
// random self-checking bench with a reference model of the core
`default_nettype none
module core_instruction_execute_subset_tb import cie_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 0, resetn = 0, instr_valid = 0, prescaler_on_timer = 0;
    logic [11:0] instr = 12'h000;
    logic [7:0]  io_pins = 8'h00, accumulator, status, io_latch;
    logic [10:0] program_counter, stack_push_addr;
    logic        stack_push, prescaler_clear, idle_op;
    logic [7:0]  m_acc, m_st, m_lat, m_mem [32];
    logic [10:0] m_pc, m_pa;
    logic        m_push, m_pcl, m_idle, m_flush;
    int          err_total = 0, check_count = 0;
    localparam logic [11:0] OP_B [8] = '{12'hE00, 12'h500, 12'h600, 12'h700,
        12'h900, 12'h140, 12'h040, 12'h000};
    localparam logic [11:0] OP_M [8] = '{12'h0FF, 12'h0FF, 12'h0FF, 12'h0FF,
        12'h0FF, 12'h03F, 12'h000, 12'hFFF};
    always #50 mclk = ~mclk;
    cie_exec_core u_dut (.mclk(mclk), .resetn(resetn), .instr_valid(instr_valid),
        .instr(instr), .io_pins(io_pins), .prescaler_on_timer(prescaler_on_timer),
        .accumulator(accumulator), .status(status), .program_counter(program_counter),
        .io_latch(io_latch), .stack_push(stack_push), .stack_push_addr(stack_push_addr),
        .prescaler_clear(prescaler_clear), .idle_op(idle_op));
    task chk(input string nm, input logic [10:0] e, input logic [10:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task mreset();
        m_acc = RST_ACC;
        m_st = RST_STATUS;
        m_lat = RST_LATCH;
        m_pc = RST_PC;
        m_pa = RST_PC;
        {m_push, m_pcl, m_idle, m_flush} = 4'h0;
        foreach (m_mem[j]) m_mem[j] = 8'h00;
    endtask
    task wr(input logic [4:0] a, input logic [7:0] v);
        if (a == 5'h03) m_st = v;
        else m_mem[a] = v;
        if (a == 5'h06) m_lat = v;
    endtask
    task model();
        logic [7:0] r, v;
        logic [4:0] f;
        f = instr[4:0];
        r = (f == 5'h03) ? m_st : (f == 5'h06) ? io_pins : m_mem[f];
        {m_push, m_pcl, m_idle} = 3'h0;
        if (!instr_valid) return;
        m_pc = m_pc + 11'h001;
        if (m_flush) begin
            m_flush = 0;
            m_idle = 1;
        end else case (instr[11:8])
            4'hE: begin
                m_acc = m_acc & instr[7:0];
                m_st[2] = (m_acc == 8'h00);
            end
            4'h5: begin
                v = r;
                v[instr[7:5]] = 1'b1;
                wr(f, v);
                m_pcl = (f == 5'h01) && prescaler_on_timer;
            end
            4'h6: m_flush = !r[instr[7:5]];
            4'h7: m_flush = r[instr[7:5]];
            4'h9: begin
                m_pa = m_pc;
                m_push = 1;
                m_pc = {m_st[6:5], 1'b0, instr[7:0]};
                m_flush = 1;
            end
            4'h1: if (instr[7:6] == 2'b01) begin
                v = m_acc & r;
                m_st[2] = (v == 8'h00);
                if (instr[5]) begin
                    wr(f, v);
                    m_pcl = (f == 5'h01) && prescaler_on_timer;
                end else m_acc = v;
            end else m_idle = 1;
            4'h0: if (instr == 12'h040) {m_acc, m_st[2]} = 9'h001;
                  else m_idle = 1;
            default: m_idle = 1;
        endcase
    endtask
    task final_report();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        int k;
        mreset();
        void'($urandom(32'h07FDA6D2));
        repeat (2) @(posedge mclk);
        #10 resetn = 1;
        for (int i = 0; i < 4000; i++) begin
            k = $urandom_range(7);
            instr = OP_B[k] | (12'($urandom) & OP_M[k]);
            instr_valid = ($urandom_range(9) != 0);
            io_pins = 8'($urandom);
            prescaler_on_timer = 1'($urandom);
            if (i == 2000) resetn = 0;
            if (i == 2002) resetn = 1;
            @(posedge mclk);
            if (resetn) model();
            else mreset();
            #10;
            chk("accumulator", {3'h0, m_acc}, {3'h0, accumulator});
            chk("status", {3'h0, m_st}, {3'h0, status});
            chk("counter", m_pc, program_counter);
            chk("io latch", {3'h0, m_lat}, {3'h0, io_latch});
            chk("push", {10'h0, m_push}, {10'h0, stack_push});
            chk("push addr", m_pa, stack_push_addr);
            chk("prescaler", {10'h0, m_pcl}, {10'h0, prescaler_clear});
            chk("idle", {10'h0, m_idle}, {10'h0, idle_op});
        end
        final_report();
    end
endmodule // core_instruction_execute_subset_tb
`default_nettype wire
